// ---- core/cvs_cfg.svh ----
// Purpose: constants for the charge voltage setpoint register block
// Assumes: byte-wide register port decoded from the serial interface
// Notes: values in mV are also given as 16-bit register codes (8 mV lsb at bit 3)
//
// Notes on behaviour
// - The charge voltage target is one 16-bit value spread over two consecutive byte addresses.
// - The target spans 1.024 V to 19.200 V in 8 mV steps.
// - A nonzero write whose value lies below 1.024 V or above 19.200 V is dropped and the target kept.
// - At power-on the target loads 4200, 8400, 12600 or 16800 mV from the cell-count pin.
// - With input good high, charging starts only once the host writes a charge current.
// - A target never programmed by the host stays at the cell-count default.
// - Writing zero to the target reloads the cell-count default instead of storing zero.
// - Writing zero to the target also forces the charge current register to zero.
// - Upper byte bits 6..0 weigh 16384 mV down to 256 mV.
// - Lower byte bits 7..3 weigh 128 mV down to 8 mV.
// - Upper byte bit 7 must be zero; a write with it set is invalid.
// - Lower byte bits 2..0 are not stored on write, but a nonzero value in them keeps the write from counting as a zero write.
`ifndef CVS_CFG_SVH
`define CVS_CFG_SVH
`define CVS_ADDR_LOW    8'h04
`define CVS_ADDR_HIGH   8'h05
`define CVS_CODE_MIN    16'h0400
`define CVS_CODE_MAX    16'h4b00
`define CVS_CODE_1S     16'h1068
`define CVS_CODE_2S     16'h20d0
`define CVS_CODE_3S     16'h3138
`define CVS_CODE_4S     16'h41a0
`define CVS_INVALID_BIT 15
`define CVS_LOW_MASK    8'hf8
`define CVS_HIGH_MASK   8'h7f
`define CVS_CODE_ZERO   16'h0000
`define CVS_STRAP_WAIT  2'h2
`endif

// ---- core/cvs_pkg.sv ----
// Purpose: types for the charge voltage setpoint block
// Assumes: nothing
// Notes: none
`default_nettype none
package cvs_pkg;
  typedef enum logic [0:0] {
    CVS_IDLE     = 1'b0,
    CVS_HAVE_LOW = 1'b1
  } cvs_phase_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } cvs_req_t;

  typedef struct packed {
    cvs_phase_t  phase;
    logic [7:0]  low_hold;
    logic [15:0] target;
    logic [1:0]  cell_sync1;
    logic [1:0]  cell_sync2;
    logic        good_sync1;
    logic        good_sync2;
    logic [7:0]  rdata;
    logic        clr_cur;
    logic        charge_en;
    logic        written;
    logic [1:0]  strap_cnt;
    logic        strap_taken;
  } cvs_state_t;
endpackage : cvs_pkg
`default_nettype wire

// ---- core/cvs_setpoint.sv ----
// Purpose: charge voltage target register pair with range check and cell default
// Assumes: register requests are synchronous to i_core_clk; pins are asynchronous
// Notes: low byte is held until the high byte arrives, then the word is checked
`include "cvs_cfg.svh"
`default_nettype none
module cvs_setpoint (
  input  wire logic             i_core_clk,
  input  wire logic             i_rst,
  input  wire logic             i_clk_en,
  input  wire cvs_pkg::cvs_req_t i_req,
  input  wire logic [1:0]       i_cell_count_select_pin,
  input  wire logic             i_input_good_indication,
  input  wire logic             i_fast_charge_written,
  output logic [7:0]            o_rdata,
  output logic [15:0]           o_battery_regulation_target,
  output logic                  o_fast_charge_clear,
  output logic                  o_charge_enable,
  output logic                  o_target_written
);
  import cvs_pkg::*;

  cvs_state_t st_ff;
  cvs_state_t nxt_st;

  ////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] cell_default(input logic [1:0] cells);
    case (cells)
      2'h0:    cell_default = `CVS_CODE_1S;
      2'h1:    cell_default = `CVS_CODE_2S;
      2'h2:    cell_default = `CVS_CODE_3S;
      default: cell_default = `CVS_CODE_4S;
    endcase
  endfunction : cell_default

  function automatic logic wr_hit(input cvs_req_t req, input logic [7:0] addr);
    wr_hit = req.wr && (req.addr == addr);
  endfunction : wr_hit
  function automatic logic rd_hit(input cvs_req_t req, input logic [7:0] addr);
    rd_hit = req.rd && (req.addr == addr);
  endfunction : rd_hit
  function automatic logic in_range(input logic [15:0] code);
    in_range = (code >= `CVS_CODE_MIN) && (code <= `CVS_CODE_MAX);
  endfunction : in_range

  logic [15:0] word;
  logic        word_ok;

  always_comb begin
    nxt_st            = st_ff;
    nxt_st.clr_cur    = 1'b0;
    nxt_st.cell_sync1 = i_cell_count_select_pin;
    nxt_st.cell_sync2 = st_ff.cell_sync1;
    nxt_st.good_sync1 = i_input_good_indication;
    nxt_st.good_sync2 = st_ff.good_sync1;
    // reserved low bits dropped; bit 15 kept so the check can reject it
    word    = {i_req.wdata, st_ff.low_hold & `CVS_LOW_MASK};
    word_ok = !word[`CVS_INVALID_BIT] && in_range(word);
    // strap caught only once the pin has crossed both synchroniser stages;
    // an earlier host write is not overwritten by the late default
    if (!st_ff.strap_taken) begin
      if (st_ff.strap_cnt == `CVS_STRAP_WAIT) begin
        if (!st_ff.written) begin
          nxt_st.target = cell_default(st_ff.cell_sync2);
        end
        nxt_st.strap_taken = 1'b1;
      end else begin
        nxt_st.strap_cnt = st_ff.strap_cnt + 2'h1;
      end
    end
    if (wr_hit(i_req, `CVS_ADDR_LOW)) begin
      nxt_st.low_hold = i_req.wdata;
      nxt_st.phase    = CVS_HAVE_LOW;
    end
    if (wr_hit(i_req, `CVS_ADDR_HIGH)) begin
      case (st_ff.phase)
        CVS_HAVE_LOW: begin
          if ({i_req.wdata, st_ff.low_hold} == `CVS_CODE_ZERO) begin
            nxt_st.target  = cell_default(st_ff.cell_sync2);
            nxt_st.clr_cur = 1'b1;
            nxt_st.written = 1'b0;
          end else if (word_ok) begin
            nxt_st.target  = word;
            nxt_st.written = 1'b1;
          end
        end
        default: begin
        end
      endcase
      nxt_st.phase = CVS_IDLE;
    end
    // charging needs input good and a written current; zero target write stops it
    if (!st_ff.good_sync2 || nxt_st.clr_cur) begin
      nxt_st.charge_en = 1'b0;
    end else if (i_fast_charge_written) begin
      nxt_st.charge_en = 1'b1;
    end
    if (i_req.rd) begin
      case (i_req.addr)
        `CVS_ADDR_LOW:  nxt_st.rdata = st_ff.target[7:0];
        `CVS_ADDR_HIGH: nxt_st.rdata = st_ff.target[15:8] & `CVS_HIGH_MASK;
        default:        nxt_st.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      st_ff <= '0;
    end else if (i_clk_en) begin
      st_ff <= nxt_st;
    end
  end

  assign o_rdata                     = st_ff.rdata;
  assign o_battery_regulation_target = st_ff.target;
  assign o_fast_charge_clear         = st_ff.clr_cur;
  assign o_charge_enable             = st_ff.charge_en;
  assign o_target_written            = st_ff.written;

  ////////////////////////////////////////////////////////////////////////
  // write path checks
  range_hold_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (i_clk_en && st_ff.strap_taken && st_ff.phase == CVS_HAVE_LOW
     && wr_hit(i_req, `CVS_ADDR_HIGH) && i_req.wdata[7]) |=> $stable(st_ff.target))
    else $error("target changed on invalid write");

  zero_clear_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    $rose(st_ff.clr_cur) |-> st_ff.target == cell_default(st_ff.cell_sync2))
    else $error("zero write did not reload default");

  target_limit_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    st_ff.written |-> in_range(st_ff.target))
    else $error("stored target out of range");

  low_only_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (i_clk_en && wr_hit(i_req, `CVS_ADDR_LOW) && st_ff.strap_taken)
    |=> $stable(st_ff.target))
    else $error("low byte alone changed target");

  charge_gate_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    st_ff.charge_en |-> $past(st_ff.good_sync2))
    else $error("charging without input good");

  lsb_ignore_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    st_ff.target[2:0] == 3'h0)
    else $error("reserved low bits stored");

  phase_low_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (i_clk_en && wr_hit(i_req, `CVS_ADDR_LOW)) |=> st_ff.phase == CVS_HAVE_LOW)
    else $error("low write did not arm the pair");

  hold_capture_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (i_clk_en && wr_hit(i_req, `CVS_ADDR_LOW)) |=> st_ff.low_hold == $past(i_req.wdata))
    else $error("low byte not held");

  hold_idle_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (i_clk_en && !wr_hit(i_req, `CVS_ADDR_LOW)) |=> $stable(st_ff.low_hold))
    else $error("held low byte changed without write");

  phase_high_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (i_clk_en && wr_hit(i_req, `CVS_ADDR_HIGH)) |=> st_ff.phase == CVS_IDLE)
    else $error("high write left the pair armed");

  lone_high_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (i_clk_en && st_ff.strap_taken && st_ff.phase == CVS_IDLE
     && wr_hit(i_req, `CVS_ADDR_HIGH)) |=> $stable(st_ff.target) && !st_ff.clr_cur)
    else $error("high byte alone acted");

  valid_store_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (i_clk_en && st_ff.phase == CVS_HAVE_LOW && wr_hit(i_req, `CVS_ADDR_HIGH) && word_ok)
    |=> st_ff.target == $past(word) && st_ff.written)
    else $error("valid word not stored");

  invalid_keep_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (i_clk_en && st_ff.strap_taken && st_ff.phase == CVS_HAVE_LOW
     && wr_hit(i_req, `CVS_ADDR_HIGH) && !word_ok
     && {i_req.wdata, st_ff.low_hold} != `CVS_CODE_ZERO) |=> $stable(st_ff.target))
    else $error("out of range word stored");

  zero_reload_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (i_clk_en && st_ff.phase == CVS_HAVE_LOW && wr_hit(i_req, `CVS_ADDR_HIGH)
     && {i_req.wdata, st_ff.low_hold} == `CVS_CODE_ZERO)
    |=> st_ff.clr_cur && !st_ff.written
        && st_ff.target == cell_default($past(st_ff.cell_sync2)))
    else $error("zero write not handled");

  target_quiet_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (i_clk_en && st_ff.strap_taken && !wr_hit(i_req, `CVS_ADDR_HIGH))
    |=> $stable(st_ff.target))
    else $error("target changed without high write");

  top_bit_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    !st_ff.target[`CVS_INVALID_BIT])
    else $error("reserved top bit stored");

  target_nonzero_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    st_ff.strap_taken |-> st_ff.target != `CVS_CODE_ZERO)
    else $error("target zero after start");

  ////////////////////////////////////////////////////////////////////////
  // strap and clear pulse checks
  strap_bound_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    st_ff.strap_cnt <= `CVS_STRAP_WAIT)
    else $error("strap counter overran");

  strap_done_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    st_ff.strap_taken |-> st_ff.strap_cnt == `CVS_STRAP_WAIT)
    else $error("strap taken early");

  strap_load_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    $rose(st_ff.strap_taken)
    |-> st_ff.written || st_ff.target == cell_default($past(st_ff.cell_sync2)))
    else $error("cell default not loaded");

  clr_pulse_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (i_clk_en && st_ff.clr_cur) |=> !st_ff.clr_cur)
    else $error("clear pulse too long");

  clr_cause_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (i_clk_en && !(wr_hit(i_req, `CVS_ADDR_HIGH) && st_ff.phase == CVS_HAVE_LOW))
    |=> !st_ff.clr_cur)
    else $error("clear without zero write");

  clr_stop_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    st_ff.clr_cur |-> !st_ff.charge_en)
    else $error("charging through clear");

  clr_unwritten_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    st_ff.clr_cur |-> !st_ff.written)
    else $error("written flag kept on zero write");

  ////////////////////////////////////////////////////////////////////////
  // charge enable checks
  en_drop_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (i_clk_en && !st_ff.good_sync2) |=> !st_ff.charge_en)
    else $error("charging kept without input good");

  en_wait_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (i_clk_en && !st_ff.charge_en && !i_fast_charge_written) |=> !st_ff.charge_en)
    else $error("charging began without current write");

  en_start_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (i_clk_en && st_ff.good_sync2 && i_fast_charge_written
     && !(wr_hit(i_req, `CVS_ADDR_HIGH) && st_ff.phase == CVS_HAVE_LOW))
    |=> st_ff.charge_en)
    else $error("charging did not begin");

  ////////////////////////////////////////////////////////////////////////
  // read path checks
  read_low_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (i_clk_en && rd_hit(i_req, `CVS_ADDR_LOW))
    |=> {8'h00, st_ff.rdata} == ($past(st_ff.target) & 16'h00ff))
    else $error("low read wrong");

  read_high_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (i_clk_en && rd_hit(i_req, `CVS_ADDR_HIGH))
    |=> {st_ff.rdata, 8'h00} == ($past(st_ff.target) & {`CVS_HIGH_MASK, 8'h00}))
    else $error("high read wrong");

  read_other_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (i_clk_en && i_req.rd && !rd_hit(i_req, `CVS_ADDR_LOW)
     && !rd_hit(i_req, `CVS_ADDR_HIGH)) |=> st_ff.rdata == 8'h00)
    else $error("unmapped read not zero");

  read_hold_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (i_clk_en && !i_req.rd) |=> $stable(st_ff.rdata))
    else $error("read data moved without read");

  ////////////////////////////////////////////////////////////////////////
  // synchroniser checks
  cell_sync_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    i_clk_en |=> st_ff.cell_sync1 == $past(i_cell_count_select_pin))
    else $error("cell pin not captured");

  cell_stage_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    i_clk_en |=> st_ff.cell_sync2 == $past(st_ff.cell_sync1))
    else $error("cell second stage wrong");

  good_sync_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    i_clk_en |=> st_ff.good_sync1 == $past(i_input_good_indication))
    else $error("input good not captured");

  good_stage_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    i_clk_en |=> st_ff.good_sync2 == $past(st_ff.good_sync1))
    else $error("input good second stage wrong");

  ////////////////////////////////////////////////////////////////////////
  // low clock enable freezes every field
  freeze_phase_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    !i_clk_en |=> $stable(st_ff.phase))
    else $error("phase moved while frozen");

  freeze_hold_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    !i_clk_en |=> $stable(st_ff.low_hold))
    else $error("held byte moved while frozen");

  freeze_target_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    !i_clk_en |=> $stable(st_ff.target))
    else $error("target moved while frozen");

  freeze_cell1_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    !i_clk_en |=> $stable(st_ff.cell_sync1))
    else $error("cell stage one moved while frozen");

  freeze_cell2_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    !i_clk_en |=> $stable(st_ff.cell_sync2))
    else $error("cell stage two moved while frozen");

  freeze_good1_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    !i_clk_en |=> $stable(st_ff.good_sync1))
    else $error("good stage one moved while frozen");

  freeze_good2_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    !i_clk_en |=> $stable(st_ff.good_sync2))
    else $error("good stage two moved while frozen");

  freeze_rdata_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    !i_clk_en |=> $stable(st_ff.rdata))
    else $error("read data moved while frozen");

  freeze_clear_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    !i_clk_en |=> $stable(st_ff.clr_cur))
    else $error("clear moved while frozen");

  freeze_enable_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    !i_clk_en |=> $stable(st_ff.charge_en))
    else $error("enable moved while frozen");

  freeze_written_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    !i_clk_en |=> $stable(st_ff.written))
    else $error("written flag moved while frozen");

  freeze_count_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    !i_clk_en |=> $stable(st_ff.strap_cnt))
    else $error("strap counter moved while frozen");

  freeze_strap_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    !i_clk_en |=> $stable(st_ff.strap_taken))
    else $error("strap flag moved while frozen");
endmodule : cvs_setpoint
`default_nettype wire

// ---- tb/cvs_host_model.sv ----
// Purpose: host model issuing register byte requests
// Assumes: requests launched on the falling edge
// Notes: released lines show inverted data, never a stale echo
`default_nettype none
module cvs_host_model (
  input  wire logic       i_core_clk,
  output var  cvs_pkg::cvs_req_t o_req
);
  timeunit 1ns;
  timeprecision 1ps;
  import cvs_pkg::*;
  initial o_req = '0;
  task automatic put(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(negedge i_core_clk);
    o_req = '{wr: w, rd: !w, addr: a, wdata: d};
    @(negedge i_core_clk);
    o_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask : put
  task automatic wr16(input logic [15:0] v);
    put(1'b1, 8'h04, v[7:0]);
    put(1'b1, 8'h05, v[15:8]);
  endtask : wr16
endmodule : cvs_host_model
`default_nettype wire

// ---- tb/tb_cvs_setpoint.sv ----
// Purpose: self-checking bench for the charge voltage setpoint block
// Assumes: inputs change on the falling edge
// Notes: clock enable held high except during the frozen write
`default_nettype none
module tb_cvs_setpoint;
  timeunit 1ns;
  timeprecision 1ps;
  import cvs_pkg::*;
  logic i_core_clk = 1'b0, i_rst = 1'b1, good = 1'b0, fcw = 1'b0;
  logic [1:0] pin = 2'h0;
  cvs_req_t req;
  logic [7:0] rdata;
  logic [15:0] tgt;
  logic clr, en, wrt;
  logic cen = 1'b1;
  int num_errors = 0, compares = 0;
  logic [15:0] dflt [4] = '{16'h1068, 16'h20d0, 16'h3138, 16'h41a0};
  always #2 i_core_clk = ~i_core_clk;
  cvs_host_model host (.i_core_clk(i_core_clk), .o_req(req));
  cvs_setpoint DUT (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_clk_en(cen),
    .i_req(req), .i_cell_count_select_pin(pin), .i_input_good_indication(good),
    .i_fast_charge_written(fcw), .o_rdata(rdata), .o_battery_regulation_target(tgt),
    .o_fast_charge_clear(clr), .o_charge_enable(en), .o_target_written(wrt));
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic do_reset(input logic [1:0] p);
    pin = p;
    i_rst = 1'b1;
    repeat (3) @(negedge i_core_clk);
    i_rst = 1'b0;
    repeat (4) @(negedge i_core_clk);
  endtask : do_reset
  // clear pulse is one cycle wide, so it is looked at right after the high byte
  task automatic wr_chk(input logic [15:0] v, input logic [15:0] exp);
    host.wr16(v);
    check("target", exp, tgt);
    check("clear", 16'(v == 16'h0), 16'(clr));
  endtask : wr_chk
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : give_verdict
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    for (int p = 0; p < 4; p++) begin
      do_reset(2'(p));
      check("default", dflt[p], tgt);
    end
    $display("test defaults done");
    wr_chk(16'h0400, 16'h0400);
    wr_chk(16'h4b07, 16'h4b00);
    wr_chk(16'h4b08, 16'h4b00);
    wr_chk(16'h03f8, 16'h4b00);
    wr_chk(16'h8400, 16'h4b00);
    wr_chk(16'h2ab8, 16'h2ab8);
    wr_chk(16'h1548, 16'h1548);
    host.put(1'b0, 8'h04, 8'h00);
    check("read low", 16'h0048, 16'(rdata));
    host.put(1'b0, 8'h05, 8'h00);
    check("read high", 16'h0015, 16'(rdata));
    host.put(1'b0, 8'h06, 8'h00);
    check("read unmapped", 16'h0000, 16'(rdata));
    host.put(1'b1, 8'h04, 8'h00);
    check("half write", 16'h1548, tgt);
    host.put(1'b1, 8'h05, 8'h20);
    check("full write", 16'h2000, tgt);
    check("written", 16'h1, 16'(wrt));
    host.put(1'b1, 8'h05, 8'h30);
    check("lone high", 16'h2000, tgt);
    cen = 1'b0;
    host.wr16(16'h3800);
    check("frozen", 16'h2000, tgt);
    cen = 1'b1;
    $display("test range done");
    good = 1'b1;
    repeat (4) @(negedge i_core_clk);
    check("idle enable", 16'h0, 16'(en));
    wr_chk(16'h3000, 16'h3000);
    fcw = 1'b1;
    @(negedge i_core_clk);
    fcw = 1'b0;
    for (int i = 0; i < 8 && en !== 1'b1; i++) @(negedge i_core_clk);
    check("enable", 16'h1, 16'(en));
    wr_chk(16'h0000, 16'h41a0);
    @(negedge i_core_clk);
    check("enable off", 16'h0, 16'(en));
    check("written off", 16'h0, 16'(wrt));
    $display("test zero write done");
    give_verdict();
  end
endmodule : tb_cvs_setpoint
`default_nettype wire
